// >>> design/dual_sar_bit_sequencer.sv
/*
 Digital sequencer of a dual 18-bit successive approximation converter: sample/hold and
 autozero control, the shared one-hot stage register, per-channel result latches, DAC and
 trim switch drive, and the two serial outputs.
 Assumes the trigger, bit clock and comparator outputs are asynchronous pins; all of them
 pass two flip-flops on clk before use. The bit clock must be well below clk / 4.
 The serial outputs trail each decision by one bit clock; a receiver that stalls for more
 than three bit periods loses words, since only the two buffer entries and the pending pair absorb a stall.
*/
`timescale 1ns/100ps
`default_nettype none
module dual_sar_bit_sequencer
    import sar_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic convertTrigger,
    input wire logic bit_clock_in,
    input wire logic compLeft,
    input wire logic compRight,
    input wire logic serialReady,
    output logic serialValid,
    output logic serialLeft,
    output logic serialRight,
    output logic serialLast,
    output logic holdMode,
    output logic autozero_switch,
    output logic [17:0] trialStrobe,
    output logic [17:0] capacitive_bit_dac_left,
    output logic [17:0] capacitive_bit_dac_right,
    output logic [17:0] trim_correction_dac_left,
    output logic [17:0] trim_correction_dac_right,
    output logic [17:0] codeLeft,
    output logic [17:0] codeRight,
    output logic codeValid
);
    // Synchroniser stages; the first stage of each is read only by the second.
    logic trigMeta;
    logic trigSync;
    logic trigPrev;
    logic clkMeta;
    logic clkSync;
    logic clkPrev;
    logic cmpLMeta;
    logic cmpLSync;
    logic cmpRMeta;
    logic cmpRSync;
    logic trigRise;
    logic bitRise;

    seq_state_e state;
    logic [18:0] stage;
    logic [17:0] latchLeft;
    logic [17:0] latchRight;
    logic [17:0] dacLeft;
    logic [17:0] dacRight;
    logic pendValid;
    serial_pair_s pendPair;
    logic bufInReady;
    logic bufOutValid;
    serial_pair_s bufOutData;
    logic [4:0] decidedIdx;
    logic heldValid;
    serial_pair_s heldPair;
    code_t next_codeLeft;
    code_t next_codeRight;

    // Index of the one-hot active stage among bits 1..18, counted from the MSB.
    function automatic logic [4:0] stage_index(input logic [18:0] s);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 0; i < RES_BITS; i++) begin
            if (s[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : stage_index

    // Reverses a latch vector, whose index 0 holds bit 1, into a code word with the MSB
    // in bit 17; both channels' results pass through it.
    function automatic code_t to_code_order(input logic [17:0] bits);
        code_t word;
        word = CODE_ZERO;
        for (int i = 0; i < RES_BITS; i++) begin
            word[RES_BITS - 1 - i] = bits[i];
        end
        return word;
    endfunction : to_code_order

    // Two-flop synchronisers for the trigger, bit clock and both comparator pins, then a history flop on trigger and bit clock for edge detection.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigMeta <= 1'b0;
            trigSync <= 1'b0;
            trigPrev <= 1'b0;
            clkMeta <= 1'b0;
            clkSync <= 1'b0;
            clkPrev <= 1'b0;
            cmpLMeta <= 1'b0;
            cmpLSync <= 1'b0;
            cmpRMeta <= 1'b0;
            cmpRSync <= 1'b0;
        end else begin
            trigMeta <= convertTrigger;
            trigSync <= trigMeta;
            trigPrev <= trigSync;
            clkMeta <= bit_clock_in;
            clkSync <= clkMeta;
            clkPrev <= clkSync;
            cmpLMeta <= compLeft;
            cmpLSync <= cmpLMeta;
            cmpRMeta <= compRight;
            cmpRSync <= cmpRMeta;
        end
    end

    // Edge pulses; a trigger rise starts a conversion and each bit clock rise steps it on.
    assign trigRise = trigSync && !trigPrev; // R1
    assign bitRise = clkSync && !clkPrev; // R10
    assign decidedIdx = stage_index(stage);

    // Track/hold state: a trigger rise enters hold for both channels at once.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= SEQ_TRACK;
            holdMode <= 1'b0;
            autozero_switch <= 1'b1;
        end else begin
            case (state)
                SEQ_TRACK: begin
                    if (trigRise) begin
                        state <= SEQ_CONVERT; // R1
                        holdMode <= 1'b1; // R1
                        autozero_switch <= 1'b0; // R1
                    end
                end
                SEQ_CONVERT: begin
                    // The 18th rise after the trigger decides bit 18 and ends the conversion.
                    if (bitRise && stage[RES_BITS - 1]) begin
                        state <= SEQ_TRACK; // R15 R3
                        holdMode <= 1'b0; // R15
                        autozero_switch <= 1'b1; // R15
                    end
                end
                default: begin
                    state <= SEQ_TRACK;
                    holdMode <= 1'b0;
                    autozero_switch <= 1'b1;
                end
            endcase
        end
    end

    // Shared one-hot stage register: bit 1 is stage[0], bit 18 is stage[17].
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage <= STAGE_IDLE;
        end else if (state == SEQ_TRACK && trigRise) begin
            stage <= STAGE_FIRST; // R4
        end else if (state == SEQ_CONVERT && bitRise) begin
            // Shift on; after bit 18 the lone one reaches stage[18], then idles out.
            stage <= {stage[17:0], 1'b0}; // R4 R20
        end else if (state == SEQ_TRACK) begin
            stage <= STAGE_IDLE; // R20
        end
    end

    // The trial strobe is the active stage itself, shared by both channels.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trialStrobe <= BITS_CLEAR;
        end else begin
            trialStrobe <= stage[17:0]; // R6 R7
        end
    end

    // Result latches: a rising bit clock strobes both comparators into the active bit.
    // A low comparator means the trial value did not exceed the held input: keep.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latchLeft <= BITS_CLEAR;
            latchRight <= BITS_CLEAR;
        end else if (state == SEQ_TRACK && trigRise) begin
            latchLeft <= BITS_CLEAR;
            latchRight <= BITS_CLEAR;
        end else if (state == SEQ_CONVERT && bitRise && stage[17:0] != BITS_CLEAR) begin
            latchLeft[decidedIdx] <= !cmpLSync; // R5 R6 R8
            latchRight[decidedIdx] <= !cmpRSync; // R5 R6 R8
        end
    end

    // DAC switches: the active bit is forced on during its test; once the stage
    // falls the stored decision takes over, so a decided bit never glitches back.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dacLeft <= BITS_CLEAR;
            dacRight <= BITS_CLEAR;
        end else if (state == SEQ_CONVERT) begin
            dacLeft <= latchLeft | stage[17:0]; // R7 R9
            dacRight <= latchRight | stage[17:0]; // R7 R9
        end else begin
            dacLeft <= latchLeft; // R9
            dacRight <= latchRight; // R9
        end
    end

    // Trim switches are driven from the same register so they move with the DAC.
    assign capacitive_bit_dac_left = dacLeft;
    assign capacitive_bit_dac_right = dacRight;
    assign trim_correction_dac_left = dacLeft; // R13
    assign trim_correction_dac_right = dacRight; // R13

    // Final codes: bit 18 is still on the comparator at the closing edge, so it joins the
    // stored bits here; latch bit 0 (bit 1, the MSB) lands in code bit 17.
    // A kept MSB trial means the input sat at or above mid-scale, a positive two's
    // complement code, so the sign is the inverted MSB decision.
    always_comb begin
        next_codeLeft = to_code_order({!cmpLSync, latchLeft[16:0]}) ^ CODE_NEG_FULL; // R14 R16
        next_codeRight = to_code_order({!cmpRSync, latchRight[16:0]}) ^ CODE_NEG_FULL; // R14 R16
    end

    // Parallel result register, loaded once per conversion at the bit 18 decision.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            codeLeft <= CODE_ZERO;
            codeRight <= CODE_ZERO;
            codeValid <= 1'b0;
        end else begin
            codeValid <= 1'b0;
            if (state == SEQ_CONVERT && bitRise && stage[RES_BITS - 1]) begin
                codeLeft <= next_codeLeft; // R14 R16
                codeRight <= next_codeRight; // R14 R16
                codeValid <= 1'b1;
            end
        end
    end

    // Decision stage: each bit pair is captured at the rise that decides it and waits
    // here for the following rise, so the serial bit trails its decision by one bit clock.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            heldValid <= 1'b0;
            heldPair <= '0;
        end else if (bitRise) begin
            heldValid <= (state == SEQ_CONVERT) && (stage[17:0] != BITS_CLEAR); // R11 R12
            // MSB first; the MSB goes out inverted so the stream is two's complement.
            heldPair.left <= stage[0] ? cmpLSync : !cmpLSync; // R11 R14 R19
            heldPair.right <= stage[0] ? cmpRSync : !cmpRSync; // R11 R14 R19
            heldPair.last <= stage[RES_BITS - 1];
        end
    end

    // Release stage: the next bit clock rise, tracking or not, hands the waiting pair on.
    // A pair the buffer refuses is held until taken or overwritten by the next rise.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pendValid <= 1'b0;
            pendPair <= '0;
        end else if (bitRise) begin
            pendValid <= heldValid; // R12
            pendPair <= heldPair; // R12
        end else if (bufInReady) begin
            pendValid <= 1'b0;
        end
    end

    // A stall beyond the buffer's two words loses pairs: the pending one is overwritten at the next rise.
    pair_buffer outBuffer (
        .clk(clk),
        .sys_rst(sys_rst),
        .inValid(pendValid),
        .inReady(bufInReady),
        .inData(pendPair),
        .outValid(bufOutValid),
        .outReady(serialReady),
        .outData(bufOutData)
    );

    // Registered serial outputs, one per channel, presented as they leave the buffer.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            serialValid <= 1'b0;
            serialLeft <= 1'b0;
            serialRight <= 1'b0;
            serialLast <= 1'b0;
        end else begin
            serialValid <= bufOutValid && serialReady;
            if (bufOutValid && serialReady) begin
                serialLeft <= bufOutData.left; // R11 R12
                serialRight <= bufOutData.right; // R11 R12
                serialLast <= bufOutData.last;
            end
        end
    end
endmodule : dual_sar_bit_sequencer
`default_nettype wire

// >>> design/sar_seq_pkg.sv
/*
 Shared constants and carrier types for the dual successive approximation bit sequencer.
 Assumes a single 40 MHz system clock; the bit clock and trigger arrive as asynchronous pins.
*/
// What the document requires
// R1: Trigger rise ends autozero, both channels hold.
// R2: Controller derives trigger and clock from 256fs.
// R3: At 4x oversampling, 64 bit clocks per period.
// R4: One-hot stage steps bit 1 to 18.
// R5: Keep bit if DAC not above input.
// R6: One sequencer drives both channels' latches.
// R7: Active stage turns trial bit on.
// R8: Next rising bit clock stores comparator decision.
// R9: Decision applied to DAC on stage fall.
// R10: Everything synchronous to external bit clock; here all logic runs on clk and steps on the synchronised bit clock rise.
// R11: One serial output per channel.
// R12: Serial bit one bit clock after latch.
// R13: Trim switch follows DAC switch decision.
// R14: Two's complement codes, major carry at mid-scale.
// R15: After conversion, return to tracking with autozero.
// R16: Result codes 1FFFF, 00000, 3FFFF, 20000 map.
// R17: Trigger low 50 ns before 19th clock.
// R18: Receiver captures serial data on rising clock.
// R19: Serial output most significant bit first.
// R20: Idle with no stage until next trigger.
package sar_seq_pkg;
    localparam int RES_BITS = 18;
    localparam int STAGES = 19;
    localparam int CLOCKS_PER_PERIOD = 64;
    localparam int BASE_RATE_HZ = 48000;
    localparam int MASTER_RATIO = 256;
    localparam int TRIG_LOW_SETUP_NS = 50;
    localparam int SYS_CLK_HZ = 40000000;
    localparam int SYS_CLK_PERIOD_NS = 25;
    // Setup before the 19th clock, in system cycles, rounded up.
    localparam int TRIG_LOW_SETUP_CYC = (TRIG_LOW_SETUP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [17:0] CODE_POS_FULL = 18'h1FFFF;
    localparam logic [17:0] CODE_ZERO = 18'h00000;
    localparam logic [17:0] CODE_ZERO_MINUS = 18'h3FFFF;
    localparam logic [17:0] CODE_NEG_FULL = 18'h20000;
    localparam logic [18:0] STAGE_IDLE = 19'h00000;
    localparam logic [18:0] STAGE_FIRST = 19'h00001;
    localparam logic [17:0] BITS_CLEAR = 18'h00000;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        SEQ_TRACK = 2'b00,
        SEQ_CONVERT = 2'b01
    } seq_state_e;

    // One serial bit pair, left and right channel, plus a last-bit marker.
    typedef struct packed {
        logic left;
        logic right;
        logic last;
    } serial_pair_s;

    typedef logic [17:0] code_t;
endpackage : sar_seq_pkg

// >>> design/pair_buffer.sv
/*
 Two-entry valid/ready buffer for serial bit pairs.
 Assumes both sides sit on the same clock as the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module pair_buffer
    import sar_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire serial_pair_s inData,
    output logic outValid,
    input wire logic outReady,
    output var serial_pair_s outData
);
    serial_pair_s store [BUF_DEPTH];
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic doWrite;
    logic doRead;

    // Ready is honest: it drops only when both entries hold a word.
    assign inReady = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData = store[rdPtr];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // Pointer and occupancy bookkeeping.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (doWrite) begin
                wrPtr <= ~wrPtr;
            end
            if (doRead) begin
                rdPtr <= ~rdPtr;
            end
            if (doWrite && !doRead) begin
                count <= count + 2'h1;
            end else if (doRead && !doWrite) begin
                count <= count - 2'h1;
            end
        end
    end

    // Storage writes; the entries need no reset since valid guards them.
    always_ff @(posedge clk) begin
        if (doWrite) begin
            store[wrPtr] <= inData;
        end
    end
endmodule : pair_buffer
`default_nettype wire

// >>> verif/sar_seq_asserts.sv
/*
 Port checker for the dual successive approximation sequencer.
 Assumes it is bound to the sequencer top and shares its clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sar_seq_checker
    import sar_seq_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic serialValid,
    input wire logic serialLeft,
    input wire logic serialRight,
    input wire logic serialLast,
    input wire logic holdMode,
    input wire logic autozero_switch,
    input wire logic [17:0] trialStrobe,
    input wire logic [17:0] capacitive_bit_dac_left,
    input wire logic [17:0] capacitive_bit_dac_right,
    input wire logic [17:0] trim_correction_dac_left,
    input wire logic [17:0] trim_correction_dac_right,
    input wire logic [17:0] codeLeft,
    input wire logic [17:0] codeRight,
    input wire logic codeValid
);
    // One clock domain, so clocking and reset are declared once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    hold_azero_a: assert property (holdMode != autozero_switch)
        else $error("hold and autozero overlap");
    stage_onehot_a: assert property ($onehot0(trialStrobe))
        else $error("more than one stage active");
    trim_follow_a: assert property (trim_correction_dac_left == capacitive_bit_dac_left
        && trim_correction_dac_right == capacitive_bit_dac_right) else $error("trim differs from dac");
    idle_stage_a: assert property (!$past(holdMode) && !holdMode |-> trialStrobe == BITS_CLEAR)
        else $error("stage active while tracking");
    stage_step_a: assert property ($past(trialStrobe) != BITS_CLEAR && $changed(trialStrobe)
        |-> trialStrobe == ($past(trialStrobe) << 1)) else $error("stage skipped");
    start_msb_a: assert property ($rose(holdMode) |-> ##[0:2] trialStrobe == 18'h00001)
        else $error("sequence did not start at msb");
    trial_on_a: assert property ($rose(trialStrobe[0])
        |-> ##[0:1] (capacitive_bit_dac_left[0] && capacitive_bit_dac_right[0])) else $error("trial bit off");
    end_track_a: assert property (codeValid |-> ##[0:2] autozero_switch)
        else $error("no return to tracking");
    last_bit_a: assert property (serialValid && serialLast
        |-> serialLeft == codeLeft[0] && serialRight == codeRight[0]) else $error("last bit wrong");
    last_delay_a: assert property (codeValid |=> (!(serialValid && serialLast)) [*8])
        else $error("lsb sent before its delay");
    // Main scenarios that the bench is meant to reach.
    cover property ($rose(holdMode));
    cover property (codeValid);
    cover property (serialValid && serialLast);
endmodule : sar_seq_checker
bind dual_sar_bit_sequencer sar_seq_checker sar_seq_checker_i(.clk(clk), .sys_rst(sys_rst),
    .serialValid(serialValid), .serialLeft(serialLeft), .serialRight(serialRight),
    .serialLast(serialLast), .holdMode(holdMode), .autozero_switch(autozero_switch),
    .trialStrobe(trialStrobe), .capacitive_bit_dac_left(capacitive_bit_dac_left),
    .capacitive_bit_dac_right(capacitive_bit_dac_right), .trim_correction_dac_left(trim_correction_dac_left),
    .trim_correction_dac_right(trim_correction_dac_right), .codeLeft(codeLeft), .codeRight(codeRight),
    .codeValid(codeValid));
`default_nettype wire

// >>> verif/controller_model.sv
/*
 Model of the controller that makes trigger and bit clock and takes both serial streams.
 Assumes the system clock; the bit clock is PERIOD system cycles long.
*/
`timescale 1ns/100ps
`default_nettype none
module controller_model
#(
    parameter int PERIOD = 12
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stallEnable,
    input wire logic serialValid,
    input wire logic serialLeft,
    input wire logic serialRight,
    input wire logic serialLast,
    output logic convertTrigger,
    output logic bit_clock_in,
    output logic serialReady,
    output logic [17:0] rxLeft,
    output logic [17:0] rxRight,
    output logic rxDone
);
    logic [3:0] phase;
    logic [5:0] bitCount;
    // One counter chain gives both trigger and clock, so they never drift apart.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase <= 4'h0;
            bitCount <= 6'h3F;
        end else begin
            phase <= (phase == 4'(PERIOD - 1)) ? 4'h0 : phase + 4'h1;
            if (phase == 4'(PERIOD - 1)) bitCount <= bitCount + 6'h01;
        end
    end
    assign bit_clock_in = phase < 4'(PERIOD / 2);
    // Short trigger pulse, low long before the 19th clock.
    assign convertTrigger = bitCount == 6'h3F && phase >= 4'h2 && phase < 4'h6;
    // Stalls stay shorter than a bit period, so the buffer never overflows.
    assign serialReady = !(stallEnable && phase < 4'h4);
    // Serial words are gathered on rising system clock edges, msb first; the design
    // pulses serialValid only for a pair it has already handed over under ready.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxLeft <= 18'h00000;
            rxRight <= 18'h00000;
            rxDone <= 1'b0;
        end else begin
            rxDone <= serialValid && serialLast;
            if (serialValid) begin
                rxLeft <= {rxLeft[16:0], serialLeft};
                rxRight <= {rxRight[16:0], serialRight};
            end
        end
    end
endmodule : controller_model
`default_nettype wire

// >>> verif/testbench.sv
/*
 Self-checking bench: comparators are modelled from the dac switches and a target code.
 Assumes the controller model in its own file and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
    import sar_seq_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic stallEnable = 1'b0;
    code_t targetLeft = CODE_ZERO;
    code_t targetRight = CODE_ZERO;
    logic convertTrigger, bit_clock_in, compLeft, compRight, serialReady, serialValid;
    logic serialLeft, serialRight, serialLast, holdMode, autozero_switch, codeValid, rxDone;
    logic [17:0] trialStrobe, dacLeft, dacRight, codeLeft, codeRight, rxLeft, rxRight;
    int failures = 0;
    int n_tests = 0;
    code_t cornerL [4] = '{CODE_POS_FULL, CODE_ZERO, CODE_ZERO_MINUS, CODE_NEG_FULL};
    code_t cornerR [4] = '{CODE_NEG_FULL, CODE_ZERO_MINUS, CODE_ZERO, CODE_POS_FULL};
    always #12.5 clk = ~clk;
    // Dac vector has the msb in bit 0; the input is held as offset binary.
    function automatic logic reject(input logic [17:0] dac, input code_t target);
        logic [17:0] r;
        for (int i = 0; i < 18; i++) r[17 - i] = dac[i];
        return r > (target ^ CODE_NEG_FULL);
    endfunction : reject
    // Successive approximation worked out bit by bit, then back to two's complement.
    function automatic code_t settle(input code_t target);
        logic [17:0] r;
        r = 18'h00000;
        for (int b = 17; b >= 0; b--) if ((r | (18'h00001 << b)) <= (target ^ CODE_NEG_FULL)) r[b] = 1'b1;
        return r ^ CODE_NEG_FULL;
    endfunction : settle
    assign compLeft = reject(dacLeft, targetLeft);
    assign compRight = reject(dacRight, targetRight);
    dual_sar_bit_sequencer dual_sar_bit_sequencer_i(.clk(clk), .sys_rst(sys_rst),
        .convertTrigger(convertTrigger), .bit_clock_in(bit_clock_in), .compLeft(compLeft),
        .compRight(compRight), .serialReady(serialReady), .serialValid(serialValid),
        .serialLeft(serialLeft), .serialRight(serialRight), .serialLast(serialLast),
        .holdMode(holdMode), .autozero_switch(autozero_switch), .trialStrobe(trialStrobe),
        .capacitive_bit_dac_left(dacLeft), .capacitive_bit_dac_right(dacRight),
        .trim_correction_dac_left(), .trim_correction_dac_right(), .codeLeft(codeLeft),
        .codeRight(codeRight), .codeValid(codeValid));
    controller_model #(.PERIOD(12)) controller_model_i(.clk(clk), .sys_rst(sys_rst),
        .stallEnable(stallEnable), .serialValid(serialValid), .serialLeft(serialLeft),
        .serialRight(serialRight), .serialLast(serialLast), .convertTrigger(convertTrigger),
        .bit_clock_in(bit_clock_in), .serialReady(serialReady), .rxLeft(rxLeft),
        .rxRight(rxRight), .rxDone(rxDone));
    // Prints the counts and the verdict, then stops the run.
    task wrap_up;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task cmp_code(input code_t got, input code_t exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_code
    // Sampled at the falling edge so registered pulses have settled.
    task wait_on(input logic useRx);
        for (int k = 0; k < 2000; k++) begin
            @(negedge clk);
            if (useRx ? rxDone === 1'b1 : codeValid === 1'b1) return;
        end
        failures++;
        $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask : wait_on
    // Corner codes around full scale and mid-scale first, random codes after.
    initial begin
        void'($urandom(32'hB08B));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            targetLeft <= (i < 4) ? cornerL[i] : code_t'($urandom());
            targetRight <= (i < 4) ? cornerR[i] : code_t'($urandom());
            stallEnable <= i[0];
            wait_on(1'b0);
            cmp_code(codeLeft, settle(targetLeft));
            cmp_code(codeRight, settle(targetRight));
            wait_on(1'b1);
            cmp_code(rxLeft, settle(targetLeft));
            cmp_code(rxRight, settle(targetRight));
        end
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
